// ===== hw/clock_divider_output_control.v
// Clock plan registers, dividers, output formatting and enable control.
//
// Notes on behaviour
// R1: Above 200 MHz needs equal outputs, no spread.
// R2: Host enables combiner, equal dividers above limit.
// R3: Host puts spread output on divider 0.
// R4: Two spread outputs at different rates unsupported.
// R5: Second divider may stay off when shared.
// R6: Aux divider offers only /2, /4, /8.
// R7: Aux from spread divider 0 carries spread.
// R8: Single-ended phases: same, opposite, or individual.
// R9: Enable pin defaults active low, pulldown.
// R10: Polarity 0: active high, pullup instead.
// R11: Setting chooses low power when both disabled.
// R12: State clock is channel-0 source over 2+field.
// R13: Host keeps state clock at most 50 MHz.
// R14: State divider written only in low power; the code also accepts the write in power-down.
// R15: Fractional divider output stays 100 to 400 MHz.
// R16: Integer is floor, numerator fraction times 2^24.
// R17: Reprogram between power-down set and release.
// R18: Outputs restart about 1 ms after release.
// R19: Autoload disable keeps written settings.
// R20: Output 1 channel select resets to 0.
// R21: Reset plan: two 100 MHz outputs, disabled.
// R22: Unlock code 0x5B opens protected registers.
// R23: Output is divider rate over channel ratio.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "clock_plan_defines.vh"
module clock_divider_output_control
#(
  parameter res_mhz = 2400,
  parameter start_delay_cycles = `START_DELAY_CYC
)
(
  input wire sys_clk,
  input wire srst,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [15:0] rdata,
  input wire oe_pin,
  output reg oe_pulldown_en,
  output reg oe_pullup_en,
  output reg [1:0] out_p,
  output reg [1:0] out_n,
  output reg aux_pin_out,
  output reg aux_pin_oe_n,
  output reg sm_clk_en,
  output reg low_power
);
  localparam [63:0] RES_FX = res_mhz * 64'h0000000001000000;
  localparam [63:0] FX_MAX = RES_FX / `FOD_MIN_MHZ;
  localparam [63:0] FX_MIN = (RES_FX + `FOD_MAX_MHZ - 1) / `FOD_MAX_MHZ;
  localparam [63:0] FX_HIGH = (RES_FX + `HIGH_OUT_MHZ - 1) / `HIGH_OUT_MHZ;
  localparam [31:0] SETTLE = start_delay_cycles;

  reg [8:0] ctrl;
  reg [7:0] unlock;
  reg [7:0] fod_int0;
  reg [7:0] fod_int1;
  reg [23:0] fod_num0;
  reg [23:0] fod_num1;
  reg [12:0] chan;
  reg [7:0] fmt;
  reg [3:0] smdiv;
  reg [2:0] oe_sync;
  reg oe_level;
  reg pd_q;
  reg [31:0] settle_cnt;
  reg [1:0] phase;
  reg aux_phase;
  reg [1:0] out_spread;
  reg aux_spread;
  reg unsupported;

  wire unlocked = (unlock == `UNLOCK_CODE);
  wire power_down = ctrl[`CTRL_PD];
  wire ctrl_wr = wr_en && (addr == `REG_CTRL);
  wire prot_wr = wr_en && unlocked; // [R22]
  // Releasing power-down with autoload enabled restores the page-0 plan.
  wire reload = ctrl_wr && power_down && !wdata[`CTRL_PD] && !wdata[`CTRL_ALD]; // [R19]
  wire oe_active = ctrl[`CTRL_POL] ? !oe_level : oe_level; // [R9] [R10]
  wire [1:0] out_en = {ctrl[`CTRL_EN1] & oe_active, ctrl[`CTRL_EN0] & oe_active};
  wire running = !power_down && !pd_q && (settle_cnt == 32'h00000000) && !low_power; // [R17] [R18]

  wire [31:0] fx0 = {fod_int0, fod_num0};
  wire [31:0] fx1 = {fod_int1, fod_num1};
  wire valid0 = (fx0 >= FX_MIN[31:0]) && (fx0 <= FX_MAX[31:0]); // [R15]
  wire valid1 = (fx1 >= FX_MIN[31:0]) && (fx1 <= FX_MAX[31:0]); // [R15]
  wire [1:0] fod_run = {running & ctrl[`CTRL_F1EN] & valid1, running & valid0}; // [R5]
  wire [1:0] fod_tick;

  frac_edge_gen fractional_divider_0_gen
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(fod_run[0]),
    .int_part(fod_int0),
    .numerator(fod_num0),
    .tick(fod_tick[0])
  );

  frac_edge_gen fractional_divider_1_gen
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(fod_run[1]),
    .int_part(fod_int1),
    .numerator(fod_num1),
    .tick(fod_tick[1])
  );

  wire [2:0] r0 = chan[`CHAN_R0_LSB+2:`CHAN_R0_LSB];
  wire [2:0] r1 = chan[`CHAN_R1_LSB+2:`CHAN_R1_LSB];
  wire [1:0] auxr = chan[`CHAN_AUXR_LSB+1:`CHAN_AUXR_LSB];
  wire [1:0] ch_src = {chan[`CHAN_S1], chan[`CHAN_S0]};
  wire o1sel = chan[`CHAN_O1SEL];
  wire auxs = chan[`CHAN_AUXS];
  wire auxf = chan[`CHAN_AUXF];
  wire [1:0] ch_in = {fod_tick[ch_src[1]], fod_tick[ch_src[0]]};
  wire [1:0] ch_tick;
  wire aux_tick;
  wire sm_tick;

  edge_ratio_div channel0_ratio
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(running),
    .tick_in(ch_in[0]),
    .ratio(8'h01 << r0), // [R23]
    .tick(ch_tick[0])
  );

  edge_ratio_div channel1_ratio
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(running),
    .tick_in(ch_in[1]),
    .ratio(8'h01 << r1), // [R23]
    .tick(ch_tick[1])
  );

  edge_ratio_div aux_div
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(running & auxf),
    .tick_in(fod_tick[auxs]),
    .ratio(8'h02 << auxr), // [R6]
    .tick(aux_tick)
  );

  edge_ratio_div sm_div
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(!srst),
    .tick_in(ch_in[0]),
    .ratio(8'h02 + {4'h0, smdiv}), // [R12]
    .tick(sm_tick)
  );

  // Output 1 follows channel 1 only when selected; output 0 always channel 0.
  wire [1:0] out_tick = {o1sel ? ch_tick[1] : ch_tick[0], ch_tick[0]};
  wire src1 = o1sel ? ch_src[1] : ch_src[0];
  wire [2:0] rat1 = o1sel ? r1 : r0;
  wire [31:0] fxo0 = ch_src[0] ? fx1 : fx0;
  wire [31:0] fxo1 = src1 ? fx1 : fx0;
  wire hi0 = out_en[0] && (r0 == 3'h0) && (fxo0 < FX_HIGH[31:0]);
  wire hi1 = out_en[1] && (rat1 == 3'h0) && (fxo1 < FX_HIGH[31:0]);
  wire same = out_en[0] && out_en[1] && (fxo0 == fxo1) && (r0 == rat1);
  wire sp0 = ctrl[`CTRL_SSC] && !ch_src[0];
  wire sp1 = ctrl[`CTRL_SSC] && !src1;
  wire high_bad = (hi0 || hi1) && !(same && !sp0 && !sp1 && ctrl[`CTRL_COMB]); // [R1] [R2]
  wire spread_bad = out_en[0] && out_en[1] && sp0 && sp1 && (r0 != rat1); // [R4]

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctrl <= `CTRL_RST; // [R9] [R21]
      unlock <= 8'h00;
    end
    else if (ctrl_wr)
    begin
      ctrl <= wdata[8:0];
    end
    else if (wr_en && (addr == `REG_UNLOCK))
    begin
      unlock <= wdata[7:0]; // [R22]
    end
  end

  always @(posedge sys_clk)
  begin
    if (srst || reload)
    begin
      fod_int0 <= `FOD_INT_RST; // [R21]
      fod_int1 <= `FOD_INT_RST;
      fod_num0 <= `FOD_NUM_RST;
      fod_num1 <= `FOD_NUM_RST;
      chan <= `CHAN_RST; // [R20] [R21]
      fmt <= `FMT_RST;
      smdiv <= `SMDIV_RST;
    end
    else if (prot_wr)
    begin
      if (addr == `REG_FRACTIONAL_DIVIDER_0_INT)
        fod_int0 <= wdata[7:0]; // [R16]
      else if (addr == `REG_FRACTIONAL_DIVIDER_0_NUMH)
        fod_num0[23:16] <= wdata[7:0];
      else if (addr == `REG_FRACTIONAL_DIVIDER_0_NUML)
        fod_num0[15:0] <= wdata;
      else if (addr == `REG_FRACTIONAL_DIVIDER_1_INT)
        fod_int1 <= wdata[7:0];
      else if (addr == `REG_FRACTIONAL_DIVIDER_1_NUMH)
        fod_num1[23:16] <= wdata[7:0];
      else if (addr == `REG_FRACTIONAL_DIVIDER_1_NUML)
        fod_num1[15:0] <= wdata;
      else if (addr == `REG_CHAN)
      begin
        chan[`CHAN_AUXR_LSB-1:0] <= wdata[`CHAN_AUXR_LSB-1:0];
        chan[12:11] <= wdata[12:11];
        if (wdata[`CHAN_AUXR_LSB+1:`CHAN_AUXR_LSB] <= `AUX_RATIO_MAX)
          chan[10:9] <= wdata[10:9]; // [R6]
      end
      else if (addr == `REG_FMT)
        fmt <= wdata[7:0]; // [R8]
      else if ((addr == `REG_SMDIV) && (power_down || low_power))
        smdiv <= wdata[3:0]; // [R14]
    end
  end

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      oe_sync <= 3'h0;
      oe_level <= 1'b0;
      oe_pulldown_en <= 1'b1;
      oe_pullup_en <= 1'b0;
      low_power <= 1'b0;
      pd_q <= 1'b0;
      settle_cnt <= 32'h00000000;
      sm_clk_en <= 1'b0;
    end
    else
    begin
      oe_sync <= {oe_sync[1:0], oe_pin};
      if (oe_sync[1] == oe_sync[2])
        oe_level <= oe_sync[2];
      oe_pulldown_en <= ctrl[`CTRL_POL]; // [R9] [R10]
      oe_pullup_en <= !ctrl[`CTRL_POL]; // [R10]
      low_power <= ctrl[`CTRL_LPE] && !out_en[0] && !out_en[1]; // [R11]
      pd_q <= power_down;
      if (power_down)
        settle_cnt <= 32'h00000000;
      else if (pd_q)
        settle_cnt <= SETTLE; // [R18]
      else if (settle_cnt != 32'h00000000)
        settle_cnt <= settle_cnt - 32'h00000001;
      sm_clk_en <= sm_tick; // [R12]
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : drv
      wire [1:0] f = fmt[4*g+1:4*g];
      wire p_ok = (f != `FMT_INDIV) || fmt[4*g+2];
      wire n_ok = (f != `FMT_INDIV) || fmt[4*g+3];
      wire n_val = (f == `FMT_INPHASE) ? phase[g] : !phase[g];
      always @(posedge sys_clk)
      begin
        if (srst || !out_en[g] || !running)
        begin
          phase[g] <= 1'b0;
          out_p[g] <= 1'b0;
          out_n[g] <= 1'b0;
        end
        else
        begin
          if (out_tick[g])
            phase[g] <= !phase[g]; // [R23]
          out_p[g] <= p_ok & phase[g]; // [R8]
          out_n[g] <= n_ok & n_val; // [R8]
        end
      end
    end
  endgenerate

  always @(posedge sys_clk)
  begin
    if (srst || !running || !auxf)
    begin
      aux_phase <= 1'b0;
      aux_pin_out <= 1'b0;
      aux_pin_oe_n <= 1'b1;
    end
    else
    begin
      if (aux_tick)
        aux_phase <= !aux_phase; // [R6]
      aux_pin_out <= aux_phase;
      aux_pin_oe_n <= 1'b0;
    end
  end

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      out_spread <= 2'h0;
      aux_spread <= 1'b0;
      unsupported <= 1'b0;
    end
    else
    begin
      out_spread <= {sp1 & out_en[1], sp0 & out_en[0]};
      aux_spread <= ctrl[`CTRL_SSC] && !auxs && auxf; // [R7]
      unsupported <= high_bad || spread_bad; // [R1] [R4]
    end
  end

  always @(posedge sys_clk)
  begin
    if (srst || !rd_en)
      rdata <= 16'h0000;
    else if (addr == `REG_CTRL)
      rdata <= {7'h00, ctrl};
    else if (addr == `REG_UNLOCK)
      rdata <= {8'h00, unlock};
    else if (addr == `REG_FRACTIONAL_DIVIDER_0_INT)
      rdata <= {8'h00, fod_int0};
    else if (addr == `REG_FRACTIONAL_DIVIDER_0_NUMH)
      rdata <= {8'h00, fod_num0[23:16]};
    else if (addr == `REG_FRACTIONAL_DIVIDER_0_NUML)
      rdata <= fod_num0[15:0];
    else if (addr == `REG_FRACTIONAL_DIVIDER_1_INT)
      rdata <= {8'h00, fod_int1};
    else if (addr == `REG_FRACTIONAL_DIVIDER_1_NUMH)
      rdata <= {8'h00, fod_num1[23:16]};
    else if (addr == `REG_FRACTIONAL_DIVIDER_1_NUML)
      rdata <= fod_num1[15:0];
    else if (addr == `REG_CHAN)
      rdata <= {3'h0, chan};
    else if (addr == `REG_FMT)
      rdata <= {8'h00, fmt};
    else if (addr == `REG_SMDIV)
      rdata <= {12'h000, smdiv};
    else if (addr == `REG_STATUS)
      rdata <= {6'h00, unlocked, oe_active, out_spread, aux_spread, low_power,
                (settle_cnt != 32'h00000000), !valid1, !valid0, unsupported};
    else
      rdata <= 16'h0000;
  end
endmodule // clock_divider_output_control
`default_nettype wire

// ===== hw/edge_ratio_div.v
// Integer divider of an edge tick stream by a run-time ratio.
`timescale 1ns/1ps
`default_nettype none
module edge_ratio_div
(
  input wire sys_clk,
  input wire srst,
  input wire run,
  input wire tick_in,
  input wire [7:0] ratio,
  output reg tick
);
  reg [7:0] cnt;
  always @(posedge sys_clk)
  begin
    if (srst || !run)
    begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end
    else if (tick_in)
    begin
      if (cnt + 8'h01 >= ratio)
      begin
        cnt <= 8'h00;
        tick <= 1'b1;
      end
      else
      begin
        cnt <= cnt + 8'h01;
        tick <= 1'b0;
      end
    end
    else
    begin
      tick <= 1'b0;
    end
  end
endmodule // edge_ratio_div
`default_nettype wire

// ===== hw/frac_edge_gen.v
// Fractional divider: emits edge ticks spaced integer plus numerator over 2^24 cycles.
`timescale 1ns/1ps
`default_nettype none
module frac_edge_gen
(
  input wire sys_clk,
  input wire srst,
  input wire run,
  input wire [7:0] int_part,
  input wire [23:0] numerator,
  output reg tick
);
  reg [8:0] cnt;
  reg [23:0] acc;
  reg extra;
  wire [24:0] acc_sum;
  wire [8:0] target;
  assign acc_sum = {1'b0, acc} + {1'b0, numerator};
  assign target = {1'b0, int_part} + {8'h00, extra};
  always @(posedge sys_clk)
  begin
    if (srst || !run)
    begin
      cnt <= 9'h000;
      acc <= 24'h000000;
      extra <= 1'b0;
      tick <= 1'b0;
    end
    else if (cnt + 9'h001 >= target)
    begin
      cnt <= 9'h000;
      acc <= acc_sum[23:0]; // [R16]
      extra <= acc_sum[24];
      tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 9'h001;
      tick <= 1'b0;
    end
  end
endmodule // frac_edge_gen
`default_nettype wire

// ===== shared/clock_plan_defines.vh
// Constants for the clock divider and output control block.
`ifndef CLOCK_PLAN_DEFINES_VH
`define CLOCK_PLAN_DEFINES_VH
`define SYS_CLK_MHZ 40
`define START_DELAY_US 1000
`define START_DELAY_CYC ((`START_DELAY_US) * (`SYS_CLK_MHZ))
`define FOD_MIN_MHZ 100
`define FOD_MAX_MHZ 400
`define HIGH_OUT_MHZ 200
`define UNLOCK_CODE 8'h5B
`define REG_CTRL 8'h00
`define REG_UNLOCK 8'h01
`define REG_FRACTIONAL_DIVIDER_0_INT 8'h02
`define REG_FRACTIONAL_DIVIDER_0_NUMH 8'h03
`define REG_FRACTIONAL_DIVIDER_0_NUML 8'h04
`define REG_FRACTIONAL_DIVIDER_1_INT 8'h05
`define REG_FRACTIONAL_DIVIDER_1_NUMH 8'h06
`define REG_FRACTIONAL_DIVIDER_1_NUML 8'h07
`define REG_CHAN 8'h08
`define REG_FMT 8'h09
`define REG_SMDIV 8'h0A
`define REG_STATUS 8'h0B
`define CTRL_PD 0
`define CTRL_ALD 1
`define CTRL_LPE 2
`define CTRL_POL 3
`define CTRL_EN0 4
`define CTRL_EN1 5
`define CTRL_COMB 6
`define CTRL_SSC 7
`define CTRL_F1EN 8
`define CHAN_R0_LSB 0
`define CHAN_R1_LSB 3
`define CHAN_S0 6
`define CHAN_S1 7
`define CHAN_O1SEL 8
`define CHAN_AUXR_LSB 9
`define CHAN_AUXS 11
`define CHAN_AUXF 12
`define FMT_O1_LSB 4
`define AUX_RATIO_MAX 2'h2
`define FMT_INDIV 2'h3
`define FMT_INPHASE 2'h1
`define CTRL_RST 9'h008
`define FOD_INT_RST 8'h0C
`define FOD_NUM_RST 24'h000000
`define CHAN_RST 13'h0009
`define FMT_RST 8'h00
`define SMDIV_RST 4'h2
`endif

// ===== verification/clock_divider_output_control_sva.sv
// Concurrent checks on the ports of the clock divider and output control block.
`timescale 1ns/1ps
`default_nettype none
module clock_divider_output_control_sva
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rdata,
  input wire logic oe_pin,
  input wire logic oe_pulldown_en,
  input wire logic oe_pullup_en,
  input wire logic [1:0] out_p,
  input wire logic [1:0] out_n,
  input wire logic aux_pin_out,
  input wire logic aux_pin_oe_n,
  input wire logic sm_clk_en,
  input wire logic low_power
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  sequence s_oe_off_lo;
    (oe_pulldown_en && oe_pin) [*8];
  endsequence
  sequence s_lp_held;
    low_power [*4];
  endsequence
  a_pull_one_hot: assert property (oe_pulldown_en != oe_pullup_en)
    else $error("pull enables not exclusive");
  a_oe_low_gate: assert property (s_oe_off_lo |-> out_p == 2'b00 && out_n == 2'b00)
    else $error("outputs run while enable pin inactive");
  a_lp_outs_quiet: assert property (s_lp_held |-> out_p == 2'b00 && !sm_clk_en)
    else $error("activity in low power");
  a_lp_entry_quiet: assert property ($rose(low_power) |-> out_p == 2'b00 && out_n == 2'b00)
    else $error("low power entered with running output");
  a_sm_pulse_gap: assert property (sm_clk_en |=> !sm_clk_en [*8])
    else $error("state clock pulses too close");
  a_out_rise_gap: assert property ($rose(out_p[0]) |=> !$rose(out_p[0]) [*8])
    else $error("output 0 faster than divider limit");
  a_aux_rise_gap: assert property ($rose(aux_pin_out) |=> !$rose(aux_pin_out) [*8])
    else $error("aux clock faster than divide by two");
  a_aux_released: assert property (aux_pin_oe_n && $past(aux_pin_oe_n) |-> !aux_pin_out)
    else $error("aux toggles while released");
endmodule // clock_divider_output_control_sva
`default_nettype wire

// ===== verification/clock_divider_output_control_tb_top.sv
// Self-checking testbench of the clock divider and output control block.
`timescale 1ns/1ps
`default_nettype none
`include "clock_plan_defines.vh"
module clock_divider_output_control_tb_top;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic oe_drv_en = 1'b0;
  logic oe_drv_val = 1'b0;
  wire logic [15:0] rdata;
  wire logic oe_pin;
  wire logic pd_en;
  wire logic pu_en;
  wire logic [1:0] out_p;
  wire logic [1:0] out_n;
  wire logic aux_out;
  wire logic aux_oe_n;
  wire logic sm_clk_en;
  wire logic low_power;
  int bad_count = 0;
  int checks_done = 0;
  int sel = 0;
  logic probe;
  always #12.5 sys_clk = ~sys_clk;
  always_comb probe = (sel == 0) ? out_p[0] : (sel == 1) ? aux_out : sm_clk_en;
  clock_divider_output_control #(.start_delay_cycles(20)) dut_u (.sys_clk(sys_clk),
    .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .oe_pin(oe_pin), .oe_pulldown_en(pd_en), .oe_pullup_en(pu_en), .out_p(out_p),
    .out_n(out_n), .aux_pin_out(aux_out), .aux_pin_oe_n(aux_oe_n), .sm_clk_en(sm_clk_en),
    .low_power(low_power));
  oe_board_model oe_u (.sys_clk(sys_clk), .drive_en(oe_drv_en), .drive_val(oe_drv_val),
    .pulldown_en(pd_en), .pullup_en(pu_en), .oe_level(oe_pin));
  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rcm(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e,
    input string nm);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk(nm, e, rdata & m);
  endtask
  task automatic rise_gap(input int s, input logic [15:0] e, input string nm);
    logic last;
    int n;
    int t0;
    int r;
    sel = s;
    r = 0;
    n = 0;
    t0 = 0;
    last = 1'b1;
    while (r < 2 && n < 600)
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (probe === 1'b1 && last === 1'b0)
      begin
        r++;
        if (r == 1)
          t0 = n;
      end
      last = probe;
    end
    if (r < 2)
    begin
      bad_count++;
      print_verdict();
    end
    chk(nm, e, 16'(n - t0));
  endtask
  task automatic t_reset();
    rcm(`REG_CTRL, 16'hFFFF, 16'h0008, "ctrl reset");
    rcm(`REG_CHAN, 16'hFFFF, 16'h0009, "chan reset");
    rcm(`REG_FRACTIONAL_DIVIDER_0_INT, 16'hFFFF, 16'h000C, "fractional_divider_0 int reset");
    rcm(`REG_SMDIV, 16'hFFFF, 16'h0002, "smdiv reset");
    rcm(8'h20, 16'hFFFF, 16'h0000, "unmapped read");
    chk("pulls", 16'h0002, {14'h0, pd_en, pu_en});
    chk("outputs off", 16'h0001, {11'h0, out_p, out_n, aux_oe_n});
  endtask
  task automatic t_lock();
    wr(`REG_FRACTIONAL_DIVIDER_0_INT, 16'h0010);
    rcm(`REG_FRACTIONAL_DIVIDER_0_INT, 16'hFFFF, 16'h000C, "locked write");
    wr(`REG_UNLOCK, 16'h005B);
    wr(`REG_FRACTIONAL_DIVIDER_0_INT, 16'h0010);
    rcm(`REG_FRACTIONAL_DIVIDER_0_INT, 16'hFFFF, 16'h0010, "unlocked write");
    wr(`REG_FRACTIONAL_DIVIDER_0_INT, 16'h000C);
  endtask
  task automatic t_polarity();
    wr(`REG_CTRL, 16'h0000);
    repeat (3) @(posedge sys_clk);
    chk("pulls high", 16'h0001, {14'h0, pd_en, pu_en});
    wr(`REG_CTRL, 16'h0008);
    repeat (3) @(posedge sys_clk);
    chk("pulls low", 16'h0002, {14'h0, pd_en, pu_en});
  endtask
  task automatic t_start();
    logic seen;
    int k;
    seen = 1'b0;
    wr(`REG_CTRL, 16'h001B);
    wr(`REG_FRACTIONAL_DIVIDER_0_INT, 16'h000C);
    wr(`REG_SMDIV, 16'h0002);
    wr(`REG_CTRL, 16'h001A);
    for (k = 0; k < 20; k++)
    begin
      @(posedge sys_clk);
      seen = seen | out_p[0];
    end
    chk("settle quiet", 16'h0000, {15'h0, seen});
    rise_gap(0, 16'd48, "out0 period");
    rise_gap(2, 16'd48, "sm period");
    oe_drv_en <= 1'b1;
    oe_drv_val <= 1'b1;
    repeat (12) @(posedge sys_clk);
    chk("oe gated", 16'h0000, {14'h0, out_p[0], out_n[0]});
    oe_drv_en <= 1'b0;
  endtask
  task automatic t_fmt(input logic [15:0] f, input int mode);
    logic bad;
    int k;
    bad = 1'b0;
    wr(`REG_FMT, f);
    repeat (4) @(posedge sys_clk);
    for (k = 0; k < 60; k++)
    begin
      @(posedge sys_clk);
      #1;
      if (out_n[0] !== (mode == 0 ? out_p[0] : mode == 1 ? ~out_p[0] : 1'b0))
        bad = 1'b1;
    end
    chk("out0 n phase", 16'h0000, {15'h0, bad});
  endtask
  task automatic t_aux();
    wr(`REG_CHAN, 16'h1401);
    repeat (3) @(posedge sys_clk);
    chk("aux driven", 16'h0000, {15'h0, aux_oe_n});
    rise_gap(1, 16'd192, "aux period");
    wr(`REG_CHAN, 16'h1601);
    rcm(`REG_CHAN, 16'hFFFF, 16'h1401, "aux ratio kept");
    wr(`REG_CTRL, 16'h009A);
    repeat (4) @(posedge sys_clk);
    rcm(`REG_STATUS, 16'h0020, 16'h0020, "aux spread");
    wr(`REG_CTRL, 16'h001A);
  endtask
  task automatic t_range();
    wr(`REG_FRACTIONAL_DIVIDER_0_INT, 16'h0005);
    repeat (4) @(posedge sys_clk);
    rcm(`REG_STATUS, 16'h0002, 16'h0002, "fractional_divider_0 too fast");
    wr(`REG_FRACTIONAL_DIVIDER_0_INT, 16'h0006);
    repeat (4) @(posedge sys_clk);
    rcm(`REG_STATUS, 16'h0002, 16'h0000, "fractional_divider_0 at limit");
    wr(`REG_FRACTIONAL_DIVIDER_0_INT, 16'h000C);
  endtask
  task automatic t_plan();
    wr(`REG_FRACTIONAL_DIVIDER_0_INT, 16'h000A);
    wr(`REG_CHAN, 16'h0000);
    repeat (3) @(posedge sys_clk);
    rcm(`REG_STATUS, 16'h0001, 16'h0001, "fast single out");
    wr(`REG_CTRL, 16'h007A);
    repeat (3) @(posedge sys_clk);
    rcm(`REG_STATUS, 16'h0001, 16'h0000, "combined fast pair");
    wr(`REG_CTRL, 16'h00BA);
    wr(`REG_FRACTIONAL_DIVIDER_0_INT, 16'h000C);
    wr(`REG_CHAN, 16'h0111);
    repeat (3) @(posedge sys_clk);
    rcm(`REG_STATUS, 16'h0001, 16'h0001, "two spread rates");
    wr(`REG_CHAN, 16'h0191);
    repeat (3) @(posedge sys_clk);
    rcm(`REG_STATUS, 16'h00C1, 16'h0040, "spread on divider 0");
    wr(`REG_CTRL, 16'h001A);
  endtask
  task automatic t_low_power();
    wr(`REG_SMDIV, 16'h0003);
    rcm(`REG_SMDIV, 16'hFFFF, 16'h0002, "smdiv refused");
    wr(`REG_CTRL, 16'h000E);
    repeat (8) @(posedge sys_clk);
    chk("low power", 16'h0001, {15'h0, low_power});
    rcm(`REG_STATUS, 16'h0010, 16'h0010, "lp status");
    wr(`REG_SMDIV, 16'h0005);
    rcm(`REG_SMDIV, 16'hFFFF, 16'h0005, "smdiv taken");
  endtask
  task automatic t_autoload();
    wr(`REG_CTRL, 16'h0009);
    wr(`REG_FRACTIONAL_DIVIDER_0_INT, 16'h0010);
    wr(`REG_CTRL, 16'h0008);
    repeat (4) @(posedge sys_clk);
    rcm(`REG_FRACTIONAL_DIVIDER_0_INT, 16'hFFFF, 16'h000C, "autoload");
    rcm(`REG_SMDIV, 16'hFFFF, 16'h0002, "autoload smdiv");
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_lock();
    t_polarity();
    t_start();
    t_fmt(16'h000D, 0);
    t_fmt(16'h000E, 1);
    t_fmt(16'h0007, 2);
    t_aux();
    t_range();
    t_plan();
    t_low_power();
    t_autoload();
    print_verdict();
  end
endmodule // clock_divider_output_control_tb_top
bind clock_divider_output_control clock_divider_output_control_sva chk_u (.sys_clk(sys_clk),
  .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .oe_pin(oe_pin), .oe_pulldown_en(oe_pulldown_en), .oe_pullup_en(oe_pullup_en),
  .out_p(out_p), .out_n(out_n), .aux_pin_out(aux_pin_out), .aux_pin_oe_n(aux_pin_oe_n),
  .sm_clk_en(sm_clk_en), .low_power(low_power));
`default_nettype wire

// ===== verification/oe_board_model.sv
// Board model of the output-enable line with the device's internal pull resistors.
`timescale 1ns/1ps
`default_nettype none
module oe_board_model
(
  input wire logic sys_clk,
  input wire logic drive_en,
  input wire logic drive_val,
  input wire logic pulldown_en,
  input wire logic pullup_en,
  output logic oe_level
);
  logic last_level = 1'b0;
  always @(posedge sys_clk)
  begin
    last_level <= oe_level;
  end
  // A released line follows the enabled pull, else it drifts away from its last value.
  always_comb
  begin
    if (drive_en)
      oe_level = drive_val;
    else if (pullup_en)
      oe_level = 1'b1;
    else if (pulldown_en)
      oe_level = 1'b0;
    else
      oe_level = ~last_level;
  end
endmodule // oe_board_model
`default_nettype wire
